//--- src/serial_consts.svh
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH
// Register word offsets (address bits 4:2)
`define OFF_STATUS      3'h0
`define OFF_DATA        3'h1
`define OFF_FRAME       3'h2
`define OFF_LINE        3'h3
`define OFF_DIV         3'h4
// Status bit positions
`define B_TXE           7
`define B_TXDONE        6
`define B_RXRDY         5
`define B_QUIET         4
`define B_OVR           3
`define B_NOISE         2
`define B_FRAME         1
`define B_PAR           0
// Frame control bit positions
`define FC_RX9          7
`define FC_TX9          6
`define FC_LPD          5
`define FC_LEN9         4
`define FC_WAKE         3
`define FC_PAR_EN       2
`define FC_PAR_ODD      1
`define FC_PAR_IRQ      0
// Line control bit positions
`define LC_TXE_IE       7
`define LC_TXDONE_IE    6
`define LC_RX_IE        5
`define LC_QUIET_IE     4
`define LC_TX_EN        3
`define LC_RX_EN        2
`define LC_MUTE         1
`define LC_BREAK        0
// Reset values
`define STATUS_RST      8'hC0
`define FRAME_RST       8'h00
`define LINE_RST        8'h00
`define DIV_RST         16'h0036
// Oversampling points
`define SMP_LAST        5'h10
`define SMP_A           5'h03
`define SMP_B           5'h05
`define SMP_C           5'h07
`define SMP_LO          5'h08
`define SMP_MID         5'h09
`define SMP_HI          5'h0A
// Quiet-line lengths in samples (10 or 11 bits)
`define QUIET8          8'hA0
`define QUIET9          8'hB0
`endif

//--- src/serial_pkg.sv
package serial_pkg;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;
   typedef enum logic [1:0] {
      TX_NONE  = 2'b00,
      TX_WORD  = 2'b01,
      TX_PREAM = 2'b10,
      TX_BRK   = 2'b11
   } tx_kind_t;
endpackage

//--- src/async_serial_status_control.sv
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "serial_consts.svh"
// Contract
// - Start bit noise if three pre-edge samples not high, or sample 3/5/7 high
// - Start bit noise if any of samples 8, 9, 10 high
// - Data bit is majority of samples 8-10; disagreement sets noise
// - Enabled event wakes from wait; halt freezes the unit, no halt exit
// - One shared request, gated by each enable and the global mask
// - Each event gated by its own enable; ready and overrun share one
// - Status resets to C0h
// - Transmit-empty sets on move to shifter; clears on status then data write
// - Holding data not moved while transmit-empty is set
// - Transmit-done only after data frames; cleared by status then data write
// - Receive-ready set on data arrival; cleared by status then data read
// - Quiet flag set on idle line; rearmed only by a new receive-ready
// - Overrun keeps held receive data; new word is lost
// - Framing fault on bad stop; overrun suppresses it
// - Parity fail sets flag, optional interrupt, status read then data access
// - Frame control resets bits 6..0 to zero
// - Nine-bit mode receives bit 9 into bit 7, sends bit 6
// - Low-power bit stops prescaler and output after current byte
// - Length bit picks 8 or 9 data bits; not changed mid-transfer
// - Wake bit picks quiet-line or address-mark wake from mute
// - Parity replaces top frame bit and is checked; applies from next byte
// - Parity select even or odd, applied from next byte
// - Parity spans low 7 or 8 data bits plus parity bit
// - False start discarded; noise kept for next valid frame
module async_serial_status_control #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             arst_n,
   // Avalon-MM slave
   input  wire logic [4:0]       address,
   input  wire logic             read,
   input  wire logic             write,
   input  wire logic [3:0]       byteenable,
   input  wire logic [31:0]      writedata,
   output logic      [31:0]      readdata,
   output logic                  waitrequest,
   // Serial line
   input  wire logic             rxd,
   output logic                  txd,
   // CPU power and interrupt context
   input  wire logic             global_irq_mask,
   input  wire logic             wait_mode,
   input  wire logic             halt_mode,
   output logic                  serial_irq,
   output logic                  wake_req
);
   initial begin
      if (DIV_W < 8 || DIV_W > 16) $error("DIV_W must be 8..16");
   end

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic any_event(input logic [7:0] f, input logic [7:0] lc,
                                      input logic [7:0] fc);
      any_event = (f[`B_TXE] & lc[`LC_TXE_IE]) |
                  (f[`B_TXDONE] & lc[`LC_TXDONE_IE]) |
                  ((f[`B_RXRDY] | f[`B_OVR]) & lc[`LC_RX_IE]) |
                  (f[`B_QUIET] & lc[`LC_QUIET_IE]) |
                  (f[`B_PAR] & fc[`FC_PAR_IRQ]);
   endfunction

   logic [7:0]        flags_r, seen_r, fc_r, lc_r, rx_buf_r, tx_hold_r;
   logic [DIV_W-1:0]  div_r, div_cnt_r;
   logic              wait_r, tick_r, te_prev_r, pream_pend_r, quiet_arm_r;
   logic [31:0]       rdata_r;
   logic [7:0]        set_v, clr_v;
   logic              taken, rd_stat, rd_data, wr_data, wr_frame, wr_line;
   serial_pkg::rx_state_t rx_st_r;
   serial_pkg::tx_kind_t  tx_kind_r;
   logic [4:0]        smp_r;
   logic [2:0]        hist_r, mid_r;
   logic [3:0]        bit_r;
   logic [8:0]        sh_r;
   logic              rx_len9_r, rx_par_r, rx_odd_r, nz_acc_r, nz_pend_r;
   logic [7:0]        quiet_cnt_r;
   logic [10:0]       tx_sh_r;
   logic [3:0]        tx_left_r, tx_smp_r;
   logic              trio_maj, trio_bad, rx_end, false_start, load_word, tx_end_word;
   logic [8:0]        word;
   logic              word_msb, par_bad, accept, quiet_hit;
   logic [2:0]        trio;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, read data registered in that cycle
   assign waitrequest = wait_r;
   assign readdata    = rdata_r;
   assign taken    = (read | write) & ~wait_r;
   assign rd_stat  = taken & read & (address[4:2] == `OFF_STATUS);
   assign rd_data  = taken & read & (address[4:2] == `OFF_DATA);
   assign wr_data  = taken & write & byteenable[0] & (address[4:2] == `OFF_DATA);
   assign wr_frame = taken & write & byteenable[0] & (address[4:2] == `OFF_FRAME);
   assign wr_line  = taken & write & byteenable[0] & (address[4:2] == `OFF_LINE);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r <= ~((read | write) & wait_r);
         if ((read | write) & wait_r) begin
            case (address[4:2])
               `OFF_STATUS: rdata_r <= {24'h00_0000, flags_r};
               `OFF_DATA:   rdata_r <= {24'h00_0000, rx_buf_r};
               `OFF_FRAME:  rdata_r <= {24'h00_0000, fc_r};
               `OFF_LINE:   rdata_r <= {24'h00_0000, lc_r};
               `OFF_DIV:    rdata_r <= {{(32-DIV_W){1'b0}}, div_r};
               default:     rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Status snapshot: only flags the CPU actually saw may be cleared
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         seen_r <= 8'h00;
      end else if (rd_stat) begin
         seen_r <= rdata_r[7:0];
      end else begin
         if (rd_data) begin
            seen_r[5:0] <= 6'h00;
         end
         if (wr_data) begin
            seen_r[7:6] <= 2'h0;
            seen_r[0]   <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= DIV_W'(`DIV_RST);
      end else if (taken & write & (address[4:2] == `OFF_DIV)) begin
         if (byteenable[0]) div_r[7:0] <= writedata[7:0];
         if (byteenable[1]) div_r[DIV_W-1:8] <= writedata[DIV_W-1:8];
      end
   end

   // Frame control: bit 7 written only by the receiver
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fc_r <= `FRAME_RST;
      end else begin
         if (wr_frame) fc_r[6:0] <= writedata[6:0];
         if (rx_end & accept & ~flags_r[`B_RXRDY] & rx_len9_r) begin
            fc_r[`FC_RX9] <= word[8];
         end
      end
   end

   // Line control; hardware clears mute on wake, a software write wins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lc_r <= `LINE_RST;
      end else if (wr_line) begin
         lc_r <= writedata[7:0];
      end else if ((quiet_hit & ~fc_r[`FC_WAKE]) |
                   (rx_end & fc_r[`FC_WAKE] & word_msb)) begin
         lc_r[`LC_MUTE] <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_hold_r <= 8'h00;
      end else if (wr_data) begin
         tx_hold_r <= writedata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags: set beats clear
   always_comb begin
      set_v = 8'h00;
      clr_v = 8'h00;
      set_v[`B_TXE]    = load_word;
      set_v[`B_TXDONE] = tx_end_word;
      if (rx_end & accept) begin
         if (flags_r[`B_RXRDY]) begin
            set_v[`B_OVR] = 1'b1;
         end else begin
            set_v[`B_RXRDY] = 1'b1;
            set_v[`B_NOISE] = nz_acc_r | trio_bad | nz_pend_r;
            set_v[`B_FRAME] = ~trio_maj;
            set_v[`B_PAR]   = par_bad;
         end
      end
      set_v[`B_QUIET] = quiet_hit & quiet_arm_r & ~lc_r[`LC_MUTE];
      if (rd_data) clr_v[5:0] = seen_r[5:0];
      if (wr_data) begin
         clr_v[7:6] = seen_r[7:6];
         clr_v[0]   = seen_r[0];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flags_r <= `STATUS_RST;
      end else begin
         flags_r <= (flags_r & ~clr_v) | set_v;
      end
   end

   // Quiet flag is rearmed only by a fresh receive-ready
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_arm_r <= 1'b0;
      end else if (set_v[`B_RXRDY]) begin
         quiet_arm_r <= 1'b1;
      end else if (set_v[`B_QUIET]) begin
         quiet_arm_r <= 1'b0;
      end
   end

   // Interrupt request and wake-up
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         serial_irq <= 1'b0;
         wake_req   <= 1'b0;
      end else begin
         serial_irq <= any_event(flags_r, lc_r, fc_r) & ~global_irq_mask;
         wake_req   <= any_event(flags_r, lc_r, fc_r) & wait_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample tick; halt and low-power (once idle) stop it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_r <= '0;
         tick_r    <= 1'b0;
      end else if (halt_mode | (fc_r[`FC_LPD] & (rx_st_r == serial_pkg::RX_IDLE) &
                               (tx_kind_r == serial_pkg::TX_NONE))) begin
         tick_r <= 1'b0;
      end else begin
         tick_r    <= (div_cnt_r == '0);
         div_cnt_r <= (div_cnt_r == '0) ? div_r : div_cnt_r - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver
   assign trio     = {rxd, mid_r[1:0]};
   assign trio_maj = maj3(trio);
   assign trio_bad = ~(&trio) & (|trio);
   assign rx_end   = tick_r & (rx_st_r == serial_pkg::RX_STOP) & (smp_r == `SMP_HI);
   assign false_start = tick_r & (rx_st_r == serial_pkg::RX_START) &
                        (smp_r == `SMP_HI) & trio_maj;
   assign word     = rx_len9_r ? sh_r : {1'b0, sh_r[8:1]};
   assign word_msb = rx_len9_r ? word[8] : word[7];
   assign par_bad  = rx_par_r & ((^word) != rx_odd_r);
   assign accept   = ~lc_r[`LC_MUTE] | (fc_r[`FC_WAKE] & word_msb);
   assign quiet_hit = tick_r & lc_r[`LC_RX_EN] &
                      (quiet_cnt_r == (fc_r[`FC_LEN9] ? `QUIET9 : `QUIET8));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_cnt_r <= 8'h00;
      end else if (tick_r) begin
         if (~rxd | (rx_st_r != serial_pkg::RX_IDLE)) begin
            quiet_cnt_r <= 8'h00;
         end else if (quiet_cnt_r != 8'hFF) begin
            quiet_cnt_r <= quiet_cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hist_r <= 3'h7;
      end else if (tick_r) begin
         hist_r <= {hist_r[1:0], rxd};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mid_r <= 3'h0;
      end else if (tick_r & ((smp_r == `SMP_LO) | (smp_r == `SMP_MID))) begin
         mid_r <= {mid_r[1:0], rxd};
      end
   end

   // Noise seen on a false start waits for the next accepted frame
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nz_pend_r <= 1'b0;
      end else if (false_start) begin
         nz_pend_r <= 1'b1;
      end else if (set_v[`B_RXRDY]) begin
         nz_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_st_r   <= serial_pkg::RX_IDLE;
         smp_r     <= 5'h00;
         bit_r     <= 4'h0;
         sh_r      <= 9'h000;
         nz_acc_r  <= 1'b0;
         rx_len9_r <= 1'b0;
         rx_par_r  <= 1'b0;
         rx_odd_r  <= 1'b0;
      end else if (tick_r) begin
         smp_r <= (smp_r == `SMP_LAST) ? 5'h01 : smp_r + 5'h01;
         case (rx_st_r)
            serial_pkg::RX_IDLE: begin
               if (lc_r[`LC_RX_EN] & ~rxd & hist_r[0]) begin
                  rx_st_r   <= serial_pkg::RX_START;
                  smp_r     <= 5'h02;
                  nz_acc_r  <= (hist_r != 3'h7);
                  rx_len9_r <= fc_r[`FC_LEN9];
                  rx_par_r  <= fc_r[`FC_PAR_EN];
                  rx_odd_r  <= fc_r[`FC_PAR_ODD];
               end
            end
            serial_pkg::RX_START: begin
               if (rxd & ((smp_r == `SMP_A) | (smp_r == `SMP_B) | (smp_r == `SMP_C))) begin
                  nz_acc_r <= 1'b1;
               end
               if (smp_r == `SMP_HI) begin
                  if (trio_maj) begin
                     rx_st_r <= serial_pkg::RX_IDLE;
                  end else if (|trio) begin
                     nz_acc_r <= 1'b1;
                  end
               end
               if (smp_r == `SMP_LAST) begin
                  rx_st_r <= serial_pkg::RX_DATA;
                  bit_r   <= 4'h0;
               end
            end
            serial_pkg::RX_DATA: begin
               if (smp_r == `SMP_HI) begin
                  sh_r <= {trio_maj, sh_r[8:1]};
                  if (trio_bad) nz_acc_r <= 1'b1;
               end
               if (smp_r == `SMP_LAST) begin
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == (rx_len9_r ? 4'h8 : 4'h7)) begin
                     rx_st_r <= serial_pkg::RX_STOP;
                  end
               end
            end
            serial_pkg::RX_STOP: begin
               // End at stop mid-bit so the next edge is not missed
               if (smp_r == `SMP_HI) rx_st_r <= serial_pkg::RX_IDLE;
            end
            default: rx_st_r <= serial_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_buf_r <= 8'h00;
      end else if (set_v[`B_RXRDY]) begin
         rx_buf_r <= word[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   assign load_word = (tx_kind_r == serial_pkg::TX_NONE) & ~lc_r[`LC_BREAK] & ~pream_pend_r &
                      lc_r[`LC_TX_EN] & ~flags_r[`B_TXE] & ~halt_mode & ~fc_r[`FC_LPD];
   assign tx_end_word = tick_r & (tx_kind_r == serial_pkg::TX_WORD) &
                        (tx_smp_r == 4'hF) & (tx_left_r == 4'h1);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         te_prev_r    <= 1'b0;
         pream_pend_r <= 1'b0;
      end else begin
         te_prev_r <= lc_r[`LC_TX_EN];
         if (lc_r[`LC_TX_EN] & ~te_prev_r) begin
            pream_pend_r <= 1'b1;
         end else if ((tx_kind_r == serial_pkg::TX_NONE) & ~lc_r[`LC_BREAK] &
                      ~halt_mode & ~fc_r[`FC_LPD]) begin
            pream_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_kind_r <= serial_pkg::TX_NONE;
         tx_sh_r   <= 11'h7FF;
         tx_left_r <= 4'h0;
         tx_smp_r  <= 4'h0;
      end else if (tx_kind_r == serial_pkg::TX_NONE) begin
         tx_smp_r  <= 4'h0;
         tx_left_r <= fc_r[`FC_LEN9] ? 4'hB : 4'hA;
         if (~halt_mode & ~fc_r[`FC_LPD]) begin
            if (lc_r[`LC_BREAK] & lc_r[`LC_TX_EN]) begin
               tx_kind_r <= serial_pkg::TX_BRK;
               tx_sh_r   <= 11'h000;
            end else if (pream_pend_r) begin
               tx_kind_r <= serial_pkg::TX_PREAM;
               tx_sh_r   <= 11'h7FF;
            end else if (load_word) begin
               tx_kind_r <= serial_pkg::TX_WORD;
               if (fc_r[`FC_LEN9]) begin
                  tx_sh_r <= {1'b1, fc_r[`FC_PAR_EN] ? ((^tx_hold_r) ^ fc_r[`FC_PAR_ODD])
                              : fc_r[`FC_TX9], tx_hold_r, 1'b0};
               end else begin
                  tx_sh_r <= {2'b11, fc_r[`FC_PAR_EN] ? ((^tx_hold_r[6:0]) ^ fc_r[`FC_PAR_ODD])
                              : tx_hold_r[7], tx_hold_r[6:0], 1'b0};
               end
            end
         end
      end else if (tick_r) begin
         tx_smp_r <= tx_smp_r + 4'h1;
         if (tx_smp_r == 4'hF) begin
            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_left_r == 4'h1) tx_kind_r <= serial_pkg::TX_NONE;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         txd <= 1'b1;
      end else begin
         txd <= (tx_kind_r == serial_pkg::TX_NONE) | tx_sh_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   AST_TXE_ON_LOAD: assert property (load_word |=> flags_r[`B_TXE])
      else $error("transmit-empty not set after load");
   AST_NO_LOAD_EMPTY: assert property (load_word |-> !flags_r[`B_TXE])
      else $error("holding data moved while empty flag set");
   AST_DONE_DATA_ONLY: assert property ($rose(flags_r[`B_TXDONE]) |->
                                        $past(tx_kind_r) == serial_pkg::TX_WORD)
      else $error("transmit-done after non-data frame");
   AST_OVR_KEEPS: assert property (rx_end & accept & flags_r[`B_RXRDY] & !rd_data
                                   |=> flags_r[`B_OVR] && $stable(rx_buf_r))
      else $error("overrun lost held data");
   AST_OVR_NO_FRAME: assert property (rx_end & flags_r[`B_RXRDY] & !flags_r[`B_FRAME]
                                      |=> !flags_r[`B_FRAME])
      else $error("framing fault raised with overrun");
   AST_IRQ_MASK: assert property (global_irq_mask |=> !serial_irq)
      else $error("request raised while masked");
   AST_HALT_FREEZE: assert property (halt_mode |=> !tick_r)
      else $error("sampling ran in halt");
   AST_SEEN_ONLY: assert property (rd_data & flags_r[`B_RXRDY] & !seen_r[`B_RXRDY]
                                   |=> flags_r[`B_RXRDY])
      else $error("unseen flag cleared");
   AST_FALSE_START: assert property (false_start |=> rx_st_r == serial_pkg::RX_IDLE
                                     ##1 !flags_r[`B_RXRDY] || $past(flags_r[`B_RXRDY]))
      else $error("false start produced data");

   COV_RX_WORD: cover property (set_v[`B_RXRDY]);
   COV_OVERRUN: cover property (set_v[`B_OVR]);
   COV_TX_DONE: cover property (tx_end_word ##1 flags_r[`B_TXDONE]);
   COV_QUIET:   cover property (set_v[`B_QUIET]);
endmodule // async_serial_status_control

//--- bench/serial_far_end.sv
`timescale 1ns/100ps
module serial_far_end #(
   parameter int BIT = 32
) (
   // Line
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;
   // Start, 8 data LSB first, stop; stp=0 forces a bad stop
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge mclk);
      end
      // Back to idle for a cycle so two frames never drive rxd in one step
      rxd <= 1'b1;
      @(posedge mclk);
   endtask
   // Mid-bit sampling of one outgoing word
   task automatic recv(output logic [7:0] d);
      int t;
      t = 0;
      while (txd !== 1'b0 && t < 9000) begin
         @(posedge mclk);
         t++;
      end
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge mclk);
         if (i < 8) d[i] = txd;
      end
   endtask
endmodule // serial_far_end

//--- bench/tb_async_serial_status_control.sv
`timescale 1ns/100ps
`include "serial_consts.svh"
module tb_async_serial_status_control;
   logic mclk = 0, arst_n = 0, read = 0, write = 0, rxd, txd, irq, wake;
   logic msk = 0, wm = 0;
   logic [4:0] address = 0;
   logic [31:0] writedata = 0, readdata;
   logic waitrequest;
   logic [7:0] v, q;
   int fail_count = 0, cmp_count = 0;
   localparam int B = 32;
   always #5 mclk = ~mclk;
   async_serial_status_control async_serial_status_control_i (.mclk(mclk), .arst_n(arst_n),
      .address(address), .read(read), .write(write), .byteenable(4'hF),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd),
      .txd(txd), .global_irq_mask(msk), .wait_mode(wm), .halt_mode(1'b0),
      .serial_irq(irq), .wake_req(wake));
   serial_far_end #(.BIT(B)) serial_far_end_i (.mclk(mclk), .txd(txd), .rxd(rxd));
   ////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int t;
      t = 0;
      @(posedge mclk);
      address <= a;
      writedata <= {24'h0, d};
      write <= w;
      read <= !w;
      do begin
         @(posedge mclk);
         t++;
      end while (waitrequest !== 1'b0 && t < 100);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] q); bus(0, a, 8'h0, q); endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d); bus(1, a, d, v); endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      rd(5'h00, v); chk("status", v, 8'hC0);
      rd(5'h08, v); chk("frame", v, 8'h00);
      rd(5'h14, v); chk("unmapped", v, 8'h00);
      // Divisor 1: a tick every 2 cycles, 16 ticks give a B-cycle bit
      wr(5'h10, 8'h01);
      wr(5'h0C, 8'h24);
      // Let the old, slower countdown run out before the first start bit
      repeat (2 * B) @(posedge mclk);
      serial_far_end_i.send(8'hA5, 1);
      repeat (4) @(posedge mclk);
      chk("irq", irq, 1'b1);
      rd(5'h00, v); chk("status", v, 8'hE0);
      rd(5'h04, v); chk("data", v, 8'hA5);
      repeat (14 * B) @(posedge mclk);
      rd(5'h00, v); chk("quiet", v, 8'hD0);
      rd(5'h04, v);
      repeat (14 * B) @(posedge mclk);
      rd(5'h00, v); chk("quiet", v, 8'hC0);
      $display("rx done");
      serial_far_end_i.send(8'h11, 1);
      serial_far_end_i.send(8'h22, 1);
      repeat (4) @(posedge mclk);
      rd(5'h00, v); chk("overrun", v & 8'hEF, 8'hE8);
      rd(5'h04, v); chk("data", v, 8'h11);
      serial_far_end_i.send(8'h5A, 0);
      repeat (4 * B) @(posedge mclk);
      rd(5'h00, v); chk("framing", v & 8'hEF, 8'hE2);
      rd(5'h04, v);
      $display("errors done");
      wr(5'h0C, 8'h04);
      wr(5'h08, 8'h05);
      serial_far_end_i.send(8'h80, 1);
      repeat (4) @(posedge mclk);
      chk("irq", irq, 1'b1);
      rd(5'h00, v); chk("parity", v & 8'hEF, 8'hE1);
      rd(5'h04, v);
      serial_far_end_i.send(8'h81, 1);
      repeat (4) @(posedge mclk);
      chk("irq", irq, 1'b0);
      rd(5'h00, v); chk("parity", v & 8'hEF, 8'hE0);
      rd(5'h04, v);
      wr(5'h08, 8'h00);
      $display("parity done");
      msk <= 1'b1;
      wm <= 1'b1;
      wr(5'h0C, 8'h80);
      repeat (3) @(posedge mclk);
      chk("irq", irq, 1'b0);
      msk <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("irq", irq, 1'b1);
      chk("wake", wake, 1'b1);
      wm <= 1'b0;
      $display("irq done");
      wr(5'h0C, 8'h08);
      repeat (12 * B) @(posedge mclk);
      rd(5'h00, v);
      fork
         serial_far_end_i.recv(v);
         begin
            wr(5'h04, 8'h3C);
            repeat (5 * B) @(posedge mclk);
            rd(5'h00, q); chk("txempty", q & 8'h80, 8'h80);
         end
      join
      chk("txword", v, 8'h3C);
      repeat (3 * B) @(posedge mclk);
      rd(5'h00, v); chk("txdone", v & 8'hC0, 8'hC0);
      $display("tx done");
      complete_run;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      complete_run;
   end
endmodule // tb_async_serial_status_control
